// ### rtl/twg_pkg.sv
/*
 Shared constants and the carrier interface-independent definitions for the
 timed register write guard: addresses, key bytes, window lengths, APB map.
 Assumes one 200 MHz clock and a synchronous active-high reset.
*/
// Contract
// - Keys 0xAA then 0x55 grant one write
// - First protected write consumes the ticket
// - Protected registers always readable
// - Ticket guards restart bit, 0xC6, 0x9D
// - Ticket never times out
// - Any single-unlock access voids ticket
// - 0xC7 bit 0 reads ticket state
// - Timed keys open 256-cycle window
// - Repeated timed keys extend the window
// - Writing 0x00 closes timed window
// - 0xC9 bit 0 reads window open
// - Software closes window when finished
// - State frozen while CPU clock stopped
// - Software cancels unlocks before sleep modes
// - Wake-up mask 0x9F needs timed window
package twg_pkg;
    localparam logic [7:0] ADDR_SINGLE_UNLOCK = 8'hC7;
    localparam logic [7:0] ADDR_TIMED_UNLOCK  = 8'hC9;
    localparam logic [7:0] ADDR_WDOG_CTRL     = 8'hD8;
    localparam logic [7:0] ADDR_MEM_CFG       = 8'hC6;
    localparam logic [7:0] ADDR_ADDR_CFG      = 8'h9D;
    localparam logic [7:0] ADDR_WAKEUP_MASK   = 8'h9F;
    localparam logic [7:0] KEY_FIRST          = 8'hAA;
    localparam logic [7:0] KEY_SECOND         = 8'h55;
    localparam logic [7:0] KEY_CLOSE          = 8'h00;
    localparam int         WDOG_RESTART_BIT   = 0;
    localparam int         FLAG_BIT           = 0;
    localparam logic [7:0] RST_WDOG_CTRL      = 8'h00;
    localparam logic [7:0] RST_MEM_CFG        = 8'h00;
    localparam logic [7:0] RST_ADDR_CFG       = 8'h00;
    localparam logic [7:0] RST_WAKEUP_MASK    = 8'hFF;
    localparam int         WINDOW_CYCLES      = 256;
    localparam int         EXTEND_CYCLES      = 256;
    localparam logic [8:0] WINDOW_LOAD        = 9'(WINDOW_CYCLES);
    localparam logic [8:0] EXTEND_LOAD        = 9'(EXTEND_CYCLES);
    // APB map of the controller end (byte offsets)
    localparam logic [7:0] APB_CMD            = 8'h00;
    localparam logic [7:0] APB_WDATA          = 8'h04;
    localparam logic [7:0] APB_STATUS         = 8'h08;
    localparam logic [7:0] APB_RDATA          = 8'h0C;
    localparam int         CMD_GO_BIT         = 0;
    localparam int         CMD_WRITE_BIT      = 1;
    localparam int         CMD_ADDR_LSB       = 8;
    localparam int         STAT_BUSY_BIT      = 0;
    localparam int         STAT_DONE_BIT      = 1;
    typedef enum logic [1:0] {KS_IDLE, KS_GOT_FIRST} twg_key_e;
endpackage : twg_pkg

// ### rtl/twg_sfr_if.sv
/*
 Special-function-register bus between the CPU side and the guard.
 Assumes one clock; strobes are one-cycle pulses, read data valid same cycle.
*/
`timescale 1ns/1ps
interface twg_sfr_if (input wire logic clk);
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport guard (input wr, input rd, input addr, input wdata, output rdata);
    modport cpu   (output wr, output rd, output addr, output wdata, input rdata);
endinterface : twg_sfr_if

// ### rtl/twg_guard.sv
/*
 Device end: single-use and timed unlock logic plus the protected registers.
 Reads of every register answer whether or not an unlock is held.
 Assumes the CPU issues at most one read or write strobe per cycle; SYS_CLK is
 the CPU clock, so a stopped clock freezes every register here.
*/
// Our own choice: register access over APB.
`timescale 1ns/1ps
module twg_guard (
    // Clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       SRST,
    // Register bus
    twg_sfr_if.guard        SFR,
    // Protected register contents and watchdog restart pulse
    output logic [7:0]      WDOG_CTRL,
    output logic [7:0]      MEM_CFG,
    output logic [7:0]      ADDR_CFG,
    output logic [7:0]      WAKEUP_MASK,
    output logic            WDOG_RESTART
);
    import twg_pkg::*;

    twg_key_e   single_st_q;
    twg_key_e   timed_st_q;
    logic       single_unlock_flag_q;
    logic [8:0] timer_q;
    logic       timed_unlock_flag;
    logic       wr_single;
    logic       wr_timed;
    logic       acc_single;
    logic       grant_single;
    logic       grant_timed;
    logic       close_timed;
    logic       use_ticket;
    logic [7:0] rdata_d;

    // Next state of a key detector after a write to its unlock address
    function automatic twg_key_e key_next(
        input twg_key_e   state,
        input logic [7:0] data
    );
        twg_key_e nxt;
        nxt = KS_IDLE;
        case (state)
            KS_IDLE: begin
                if (data == KEY_FIRST) begin
                    nxt = KS_GOT_FIRST;
                end else begin
                    nxt = KS_IDLE;
                end
            end
            KS_GOT_FIRST: begin
                nxt = KS_IDLE;
            end
            default: begin
                nxt = KS_IDLE;
            end
        endcase
        return nxt;
    endfunction : key_next

    // Second key byte right after the first completes the sequence
    function automatic logic key_done(
        input twg_key_e   state,
        input logic [7:0] data
    );
        logic done;
        done = 1'b0;
        case (state)
            KS_GOT_FIRST: begin
                done = (data == KEY_SECOND);
            end
            default: begin
                done = 1'b0;
            end
        endcase
        return done;
    endfunction : key_done

    // Registers whose writes spend the single-use ticket
    function automatic logic is_ticket_reg(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            ADDR_WDOG_CTRL: hit = 1'b1;
            ADDR_MEM_CFG:   hit = 1'b1;
            ADDR_ADDR_CFG:  hit = 1'b1;
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction : is_ticket_reg

    assign wr_single         = SFR.wr && SFR.addr == ADDR_SINGLE_UNLOCK;
    assign wr_timed          = SFR.wr && SFR.addr == ADDR_TIMED_UNLOCK;
    assign acc_single        = (SFR.wr || SFR.rd) && SFR.addr == ADDR_SINGLE_UNLOCK;
    assign timed_unlock_flag = timer_q != 9'h000;
    assign grant_single      = wr_single && key_done(single_st_q, SFR.wdata);
    assign grant_timed       = wr_timed && key_done(timed_st_q, SFR.wdata);
    assign close_timed       = wr_timed && SFR.wdata == KEY_CLOSE;
    // Any write to a guarded address spends the ticket
    assign use_ticket        = SFR.wr && single_unlock_flag_q && is_ticket_reg(SFR.addr);

    // Single-use key detector
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            single_st_q <= KS_IDLE;
        end else if (wr_single) begin
            single_st_q <= key_next(single_st_q, SFR.wdata);
        end
    end

    // Single-use ticket, no timeout
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            single_unlock_flag_q <= 1'b0;
        end else if (grant_single) begin
            single_unlock_flag_q <= 1'b1;
        end else if (acc_single || use_ticket) begin
            single_unlock_flag_q <= 1'b0;
        end
    end

    // Timed key detector
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            timed_st_q <= KS_IDLE;
        end else if (wr_timed) begin
            timed_st_q <= key_next(timed_st_q, SFR.wdata);
        end
    end

    // Timed window counter
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            timer_q <= 9'h000;
        end else if (grant_timed) begin
            timer_q <= timed_unlock_flag ? EXTEND_LOAD : WINDOW_LOAD;
        end else if (close_timed) begin
            timer_q <= 9'h000;
        end else if (timed_unlock_flag) begin
            timer_q <= timer_q - 9'h001;
        end
    end

    // Watchdog control; without a ticket every bit but the restart bit is written
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            WDOG_CTRL <= RST_WDOG_CTRL;
        end else if (SFR.wr && SFR.addr == ADDR_WDOG_CTRL) begin
            WDOG_CTRL <= SFR.wdata;
            // Without a ticket the restart bit keeps its value
            if (!single_unlock_flag_q) begin
                WDOG_CTRL[WDOG_RESTART_BIT] <= WDOG_CTRL[WDOG_RESTART_BIT];
            end
        end
    end

    // One-cycle restart pulse, only when a ticket is spent
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            WDOG_RESTART <= 1'b0;
        end else begin
            WDOG_RESTART <= use_ticket && SFR.addr == ADDR_WDOG_CTRL
                && SFR.wdata[WDOG_RESTART_BIT];
        end
    end

    // Memory configuration, one write per ticket
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            MEM_CFG <= RST_MEM_CFG;
        end else if (use_ticket && SFR.addr == ADDR_MEM_CFG) begin
            MEM_CFG <= SFR.wdata;
        end
    end

    // Address configuration, one write per ticket
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ADDR_CFG <= RST_ADDR_CFG;
        end else if (use_ticket && SFR.addr == ADDR_ADDR_CFG) begin
            ADDR_CFG <= SFR.wdata;
        end
    end

    // Wake-up mask, writable only inside the timed window
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            WAKEUP_MASK <= RST_WAKEUP_MASK;
        end else if (SFR.wr && SFR.addr == ADDR_WAKEUP_MASK && timed_unlock_flag) begin
            WAKEUP_MASK <= SFR.wdata;
        end
    end

    // Read mux, always answers
    always_comb begin
        rdata_d = 8'h00;
        case (SFR.addr)
            ADDR_SINGLE_UNLOCK: rdata_d[FLAG_BIT] = single_unlock_flag_q;
            ADDR_TIMED_UNLOCK:  rdata_d[FLAG_BIT] = timed_unlock_flag;
            ADDR_WDOG_CTRL:     rdata_d = WDOG_CTRL;
            ADDR_MEM_CFG:       rdata_d = MEM_CFG;
            ADDR_ADDR_CFG:      rdata_d = ADDR_CFG;
            ADDR_WAKEUP_MASK:   rdata_d = WAKEUP_MASK;
            default:            rdata_d = 8'h00;
        endcase
    end
    assign SFR.rdata = rdata_d;
endmodule : twg_guard

// ### rtl/twg_cpu_port.sv
/*
 Other end: APB-programmed master that issues single SFR reads and writes.
 Assumes software writes the data register, then the command register.
*/
`timescale 1ns/1ps
module twg_cpu_port (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Register bus
    twg_sfr_if.cpu           SFR
);
    import twg_pkg::*;

    logic       go_q;
    logic       wr_q;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic       done_q;
    logic       apb_wr;

    assign apb_wr  = PSEL && PENABLE && PWRITE;
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;

    // Command capture; key sequences are software-driven
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            go_q    <= 1'b0;
            wr_q    <= 1'b0;
            addr_q  <= 8'h00;
        end else if (apb_wr && PADDR == APB_CMD) begin
            go_q    <= PWDATA[CMD_GO_BIT];
            wr_q    <= PWDATA[CMD_WRITE_BIT];
            addr_q  <= PWDATA[CMD_ADDR_LSB +: 8];
        end else begin
            go_q    <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            wdata_q <= 8'h00;
        end else if (apb_wr && PADDR == APB_WDATA) begin
            wdata_q <= PWDATA[7:0];
        end
    end

    // Read result and done flag; a new command wins over the clear
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rdata_q <= 8'h00;
            done_q  <= 1'b0;
        end else if (go_q) begin
            if (!wr_q) begin
                rdata_q <= SFR.rdata;
            end
            done_q  <= 1'b1;
        end else if (PSEL && PENABLE && !PWRITE && PADDR == APB_STATUS) begin
            done_q  <= 1'b0;
        end
    end

    assign SFR.wr    = go_q && wr_q;
    assign SFR.rd    = go_q && !wr_q;
    assign SFR.addr  = addr_q;
    assign SFR.wdata = wdata_q;

    always_comb begin
        PRDATA = 32'h0000_0000;
        case (PADDR)
            APB_CMD:    PRDATA = {16'h0000, addr_q, 6'h00, wr_q, 1'b0};
            APB_WDATA:  PRDATA = {24'h000000, wdata_q};
            APB_STATUS: PRDATA = {30'h0, done_q, go_q};
            APB_RDATA:  PRDATA = {24'h000000, rdata_q};
            default:    PRDATA = 32'h0000_0000;
        endcase
    end
endmodule : twg_cpu_port

// ### dv/twg_checker.sv
/*
 Assertions on the SFR bus that joins the two ends, with a small model.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module twg_checker import twg_pkg::*; (
    input wire logic       clk,
    input wire logic       SRST,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    logic       k7_q, k9_q, tk_q;
    logic [8:0] win_q;
    logic [7:0] mc_q, ac_q, wk_q;
    wire w7 = wr && addr == ADDR_SINGLE_UNLOCK;
    wire w9 = wr && addr == ADDR_TIMED_UNLOCK;
    wire g7 = w7 && wdata == KEY_SECOND && k7_q;
    wire g9 = w9 && wdata == KEY_SECOND && k9_q;
    wire r7 = rd && addr == ADDR_SINGLE_UNLOCK;
    wire wp = wr && (addr == ADDR_WDOG_CTRL || addr == ADDR_MEM_CFG || addr == ADDR_ADDR_CFG);
    default clocking cb @(posedge clk); endclocking
    default disable iff (SRST);
    // Reference model of tickets, window and protected contents
    always_ff @(posedge clk) begin
        k7_q  <= SRST ? 1'b0 : w7 ? wdata == KEY_FIRST && !k7_q : k7_q;
        k9_q  <= SRST ? 1'b0 : w9 ? wdata == KEY_FIRST && !k9_q : k9_q;
        tk_q  <= SRST ? 1'b0 : g7 ? 1'b1 : (w7 || r7 || wp) ? 1'b0 : tk_q;
        win_q <= SRST ? 9'h000 : g9 ? ((win_q != 0) ? EXTEND_LOAD : WINDOW_LOAD) :
                 (w9 && wdata == KEY_CLOSE) ? 9'h000 : win_q - 9'(win_q != 0);
        mc_q  <= SRST ? RST_MEM_CFG : (wr && addr == ADDR_MEM_CFG && tk_q) ? wdata : mc_q;
        ac_q  <= SRST ? RST_ADDR_CFG : (wr && addr == ADDR_ADDR_CFG && tk_q) ? wdata : ac_q;
        wk_q  <= SRST ? RST_WAKEUP_MASK :
                 (wr && addr == ADDR_WAKEUP_MASK && win_q != 0) ? wdata : wk_q;
    end
    a_ticket_grant: assert property (g7 |=> rdata[0]) else $error("no grant");
    a_ticket_flag: assert property (r7 |-> rdata[0] == tk_q) else $error("bad flag");
    a_access_void: assert property ((w7 && !g7) || r7 |=> !rdata[0])
        else $error("no void");
    a_memcfg_write: assert property (wr && addr == ADDR_MEM_CFG && tk_q |=>
        rdata == $past(wdata)) else $error("write lost");
    a_memcfg_read: assert property (rd && addr == ADDR_MEM_CFG |-> rdata == mc_q)
        else $error("bad content");
    a_addrcfg_read: assert property (rd && addr == ADDR_ADDR_CFG |-> rdata == ac_q)
        else $error("bad content");
    a_wakemask_read: assert property (rd && addr == ADDR_WAKEUP_MASK |-> rdata == wk_q)
        else $error("bad mask");
    a_window_open: assert property (g9 |=> rdata[0]) else $error("window shut");
    a_window_flag: assert property (rd && addr == ADDR_TIMED_UNLOCK |->
        rdata[0] == (win_q != 0)) else $error("bad window");
    a_window_close: assert property (w9 && wdata == KEY_CLOSE |=> !rdata[0])
        else $error("window open");
    c_grant: cover property (g7);
    c_open: cover property (g9);
    c_expire: cover property (win_q == 9'h001);
endmodule : twg_checker

// ### dv/timed_register_write_guard_tb_top.sv
/*
 Testbench joining the guard and the APB-driven CPU end.
 Assumes a 200 MHz clock that the bench may stop, and 5 reset cycles.
*/
`timescale 1ns/1ps
module timed_register_write_guard_tb_top;
    import twg_pkg::*;
    logic        sys_clk = 0, srst = 1, clk_stop = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, wdog_ctrl, mem_cfg, addr_cfg, wakeup_mask;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, wdog_restart;
    int          err_count = 0, comparisons = 0, restarts = 0;
    always #2.5 if (!clk_stop) sys_clk = ~sys_clk;
    twg_sfr_if sfr (.clk(sys_clk));
    twg_guard i_twg_guard (.SYS_CLK(sys_clk), .SRST(srst), .SFR(sfr), .WDOG_CTRL(wdog_ctrl),
        .MEM_CFG(mem_cfg), .ADDR_CFG(addr_cfg), .WAKEUP_MASK(wakeup_mask),
        .WDOG_RESTART(wdog_restart));
    twg_cpu_port i_twg_cpu_port (.SYS_CLK(sys_clk), .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(), .SFR(sfr));
    twg_checker i_twg_checker (.clk(sys_clk), .SRST(srst), .wr(sfr.wr), .rd(sfr.rd),
        .addr(sfr.addr), .wdata(sfr.wdata), .rdata(sfr.rdata));
    always @(posedge sys_clk) if (wdog_restart === 1'b1) restarts <= restarts + 1;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic sfr_op(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        logic [31:0] r;
        apb(1'b1, APB_WDATA, {24'h0, d}, r);
        apb(1'b1, APB_CMD, {16'h0, a, 6'h0, w, 1'b1}, r);
        do apb(1'b0, APB_STATUS, 32'h0, r); while (r[STAT_DONE_BIT] !== 1'b1);
        apb(1'b0, APB_RDATA, 32'h0, r);
        q = r[7:0];
    endtask : sfr_op
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        sfr_op(1'b1, a, d, q);
    endtask : wr
    task automatic flag(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        sfr_op(1'b0, a, 8'h00, q);
        check(q & 8'h01, exp);
    endtask : flag
    task automatic keys(input logic [7:0] a);
        wr(a, KEY_FIRST);
        wr(a, KEY_SECOND);
    endtask : keys
    task automatic t_single;
        logic [7:0] q;
        wr(ADDR_MEM_CFG, 8'h01);
        check(mem_cfg, RST_MEM_CFG);
        keys(ADDR_SINGLE_UNLOCK);
        repeat (300) @(posedge sys_clk);
        wr(ADDR_MEM_CFG, 8'h5A);
        check(mem_cfg, 8'h5A);
        wr(ADDR_MEM_CFG, 8'h33);
        sfr_op(1'b0, ADDR_MEM_CFG, 8'h00, q);
        check(q, 8'h5A);
        keys(ADDR_SINGLE_UNLOCK);
        flag(ADDR_SINGLE_UNLOCK, 8'h01);
        wr(ADDR_ADDR_CFG, 8'hA5);
        check(addr_cfg, RST_ADDR_CFG);
        wr(ADDR_SINGLE_UNLOCK, KEY_FIRST);
        wr(ADDR_SINGLE_UNLOCK, 8'h12);
        wr(ADDR_SINGLE_UNLOCK, KEY_SECOND);
        wr(ADDR_ADDR_CFG, 8'hA5);
        check(addr_cfg, RST_ADDR_CFG);
        keys(ADDR_SINGLE_UNLOCK);
        wr(ADDR_ADDR_CFG, 8'hA5);
        check(addr_cfg, 8'hA5);
        wr(ADDR_WDOG_CTRL, 8'h81);
        check(8'(restarts), 8'h00);
        check(wdog_ctrl, 8'h80);
        keys(ADDR_SINGLE_UNLOCK);
        wr(ADDR_WDOG_CTRL, 8'h01);
        check(8'(restarts), 8'h01);
        check(wdog_ctrl, 8'h01);
    endtask : t_single
    task automatic t_timed;
        wr(ADDR_WAKEUP_MASK, 8'h00);
        check(wakeup_mask, RST_WAKEUP_MASK);
        keys(ADDR_TIMED_UNLOCK);
        flag(ADDR_TIMED_UNLOCK, 8'h01);
        wr(ADDR_WAKEUP_MASK, 8'h0F);
        wr(ADDR_WAKEUP_MASK, 8'h0E);
        check(wakeup_mask, 8'h0E);
        repeat (260) @(posedge sys_clk);
        wr(ADDR_WAKEUP_MASK, 8'h00);
        check(wakeup_mask, 8'h0E);
        keys(ADDR_TIMED_UNLOCK);
        repeat (200) @(posedge sys_clk);
        keys(ADDR_TIMED_UNLOCK);
        repeat (200) @(posedge sys_clk);
        flag(ADDR_TIMED_UNLOCK, 8'h01);
        wr(ADDR_TIMED_UNLOCK, KEY_CLOSE);
        flag(ADDR_TIMED_UNLOCK, 8'h00);
    endtask : t_timed
    task automatic t_freeze;
        keys(ADDR_TIMED_UNLOCK);
        keys(ADDR_SINGLE_UNLOCK);
        @(negedge sys_clk);
        clk_stop = 1'b1;
        #2001;
        clk_stop = 1'b0;
        flag(ADDR_TIMED_UNLOCK, 8'h01);
        @(posedge sys_clk) srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        flag(ADDR_SINGLE_UNLOCK, 8'h00);
        flag(ADDR_TIMED_UNLOCK, 8'h00);
        keys(ADDR_TIMED_UNLOCK);
        keys(ADDR_SINGLE_UNLOCK);
        flag(ADDR_SINGLE_UNLOCK, 8'h01);
        wr(ADDR_TIMED_UNLOCK, KEY_CLOSE);
        @(negedge sys_clk);
        clk_stop = 1'b1;
        #2001;
        clk_stop = 1'b0;
        flag(ADDR_SINGLE_UNLOCK, 8'h00);
        flag(ADDR_TIMED_UNLOCK, 8'h00);
    endtask : t_freeze
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        t_single();
        t_timed();
        t_freeze();
        final_report();
    end
    initial begin
        #100000;
        err_count++;
        final_report();
    end
endmodule : timed_register_write_guard_tb_top
